//--- hw/fantm_cfg.svh
// register map, field positions, reset values and timing counts
`ifndef FANTM_CFG_SVH
`define FANTM_CFG_SVH
`define FANTM_IDX_CFG1    8'h00
`define FANTM_IDX_CFG2    8'h01
`define FANTM_IDX_STAT1   8'h02
`define FANTM_IDX_STAT2   8'h03
`define FANTM_IDX_FTEST   8'h07
`define FANTM_IDX_SPD1    8'h08
`define FANTM_IDX_SPD2    8'h09
`define FANTM_IDX_LIM1    8'h10
`define FANTM_IDX_LIM2    8'h11
`define FANTM_IDX_CHAR1   8'h20
`define FANTM_IDX_CHAR2   8'h21
`define FANTM_IDX_SPDSET  8'h22
`define FANTM_IDX_FILT    8'h23
`define FANTM_IDX_LTMR    8'h24
`define FANTM_IDX_R1TMR   8'h25
`define FANTM_IDX_R2TMR   8'h26
`define FANTM_IDX_DEVID   8'h3D
`define FANTM_IDX_MAKID   8'h3E
`define FANTM_IDX_BEHREV  8'h3F
`define FANTM_IDX_DUTY    8'h40
`define FANTM_RST_CFG1    8'h90
`define FANTM_RST_CFG2    8'h7F
`define FANTM_RST_CHAR    8'h5D
`define FANTM_RST_SPDSET  8'h55
`define FANTM_RST_FILT    8'h50
`define FANTM_RST_LTMR    8'h41
`define FANTM_RST_RTMR    8'h61
`define FANTM_RST_LIM     8'hFF
`define FANTM_RST_DUTY    8'h80
`define FANTM_RST_BEH     8'h00
`define FANTM_BIT_MON     0
`define FANTM_BIT_INV     3
`define FANTM_BIT_FFEN    4
`define FANTM_BIT_MEAS1   2
`define FANTM_BIT_MEAS2   3
`define FANTM_BIT_FAIL1   1
`define FANTM_BIT_FAIL2   2
`define FANTM_BIT_RNG_HI  7
`define FANTM_BIT_RNG_LO  6
`define FANTM_FAIL_RUN    3'h5
`define FANTM_CLK_HZ      125000000
`define FANTM_REF_HZ      11250
`define FANTM_REF_DIV     (`FANTM_CLK_HZ / `FANTM_REF_HZ)
`define FANTM_SPIN_MS     2000
`define FANTM_SPIN_CYC    (`FANTM_CLK_HZ / 1000 * `FANTM_SPIN_MS)
`endif

//--- hw/fantm_pkg.sv
// types shared by the fan tach measurement block
package fantm_pkg;
    typedef enum logic [3:0] {
        FANTM_IDLE = 4'b0001,
        FANTM_ARM  = 4'b0010,
        FANTM_CNT  = 4'b0100,
        FANTM_DONE = 4'b1000
    } fantm_state_e;
    typedef struct packed {
        logic [7:0] paddr;
        logic       pwrite;
        logic [7:0] pwdata;
    } fantm_req_s;
endpackage

//--- hw/fantm_top.sv
// two-channel fan tach period measurement and fan-failure logic
// Summary of operation
// - period measured by gating 11.25 kHz into counter
// - pwm base rising edge rearms measurement when enabled
// - count from second to fourth tach edge
// - measurements repeat, each stored per fan
// - characteristics bits 7:6 divide reference by 1, 2, 4 or 8
// - invert bit makes pin high at full duty
// - fault pin active-low open-drain, enable bit
// - fault asserts after five consecutive failures
// - failure only when reading exceeds limit
// - failure sets status bit and interrupt
// - status read clears interrupt output
// - each failure forces spin-up drive, high with invert bit set, low with it clear
// - measurement continues after fault asserts
// - recovery negates fault, restores normal drive
// - behavior register: revision low, bit 7 enable
// - read-only part and maker identification codes
// - monitor bit enables measurement, clear at reset
`include "fantm_cfg.svh"
module fantm_top
    import fantm_pkg::*;
#(
    parameter int         SPIN_CYC = `FANTM_SPIN_CYC,
    parameter int         REF_DIV_CYC = `FANTM_REF_DIV,
    parameter logic [7:0] PART_ID  = 8'hA5, // arbitrary value
    parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
    parameter logic [3:0] REVISION = 4'h1
)(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // fan pins
    input  wire logic [1:0]  tach_sense_in,
    output logic      [1:0]  fan_drive_out,
    output logic             fan_fault_o,
    output logic             fan_fault_oe_n,
    output logic             int_o
);
    localparam int         DIV_W  = 14;
    localparam logic [DIV_W-1:0] REF_DIV = DIV_W'(REF_DIV_CYC - 1);
    localparam int         SPIN_W = $clog2(SPIN_CYC + 1);

    function automatic logic [7:0] range_mask(input logic [1:0] sel);
        range_mask = (8'h01 << sel) - 8'h01;
    endfunction

    // registers
    logic [7:0] cfg1_ff, cfg2_ff, spdset_ff, filt_ff, duty_ff, beh_ff;
    logic [7:0] ltmr_ff, r1tmr_ff, r2tmr_ff;
    logic [7:0] char_ff [2];
    logic [7:0] lim_ff  [2];
    logic [7:0] spd_ff  [2];
    logic [7:0] stat1_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff, pslverr_ff, int_ff;
    logic [1:0]  drive_ff;
    logic        fault_ff;

    // apb decode
    fantm_req_s req;
    assign req = '{paddr: paddr[9:2], pwrite: pwrite, pwdata: pwdata[7:0]};
    wire        bus_go   = psel & penable & ~pready_ff;
    wire        wr_go    = bus_go & req.pwrite;
    wire        rd_go    = bus_go & ~req.pwrite;
    wire        addr_ok  = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0);
    wire [7:0]  idx      = req.paddr;
    wire        stat_rd  = rd_go & addr_ok & (idx == `FANTM_IDX_STAT1);

    // reference tick: pclk divided to 11.25 kHz
    logic [DIV_W-1:0] div_ff;
    logic [7:0]       pre_ff;
    wire              ref_tick = (div_ff == REF_DIV);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_ff <= '0;
            pre_ff <= '0;
        end
        else if (clk_en)
        begin
            div_ff <= ref_tick ? '0 : div_ff + 1'b1;
            if (ref_tick)
                pre_ff <= pre_ff + 8'h01;
        end
    end

    // synchronised tach inputs
    logic [1:0] tach_s1_ff, tach_s2_ff, tach_d_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tach_s1_ff <= '0;
            tach_s2_ff <= '0;
            tach_d_ff  <= '0;
        end
        else if (clk_en)
        begin
            tach_s1_ff <= tach_sense_in;
            tach_s2_ff <= tach_s1_ff;
            tach_d_ff  <= tach_s2_ff;
        end
    end
    wire [1:0] tach_rise = tach_s2_ff & ~tach_d_ff;

    // pwm base: free 8-bit ramp at the reference rate
    wire       pwm_raw  = (pre_ff < duty_ff) || (duty_ff == 8'hFF);
    logic      pwm_d_ff;
    wire       pwm_rise = pwm_raw & ~pwm_d_ff;
    wire       monitor  = cfg1_ff[`FANTM_BIT_MON];
    wire [1:0] meas_en  = {cfg2_ff[`FANTM_BIT_MEAS2],
                           cfg2_ff[`FANTM_BIT_MEAS1]};

    // per-channel measurement
    fantm_state_e    st_ff   [2];
    logic [1:0]      edge_ff [2];
    logic [7:0]      cnt_ff  [2];
    logic [2:0]      run_ff  [2];
    logic [SPIN_W-1:0] spin_ff [2];
    logic [1:0]      fail_ev;
    logic [1:0]      fault_ch;

    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        wire [1:0] rsel  = char_ff[c][`FANTM_BIT_RNG_HI:`FANTM_BIT_RNG_LO];
        wire cnt_tick    = ref_tick &
                           ((pre_ff & range_mask(rsel)) == 8'h00);
        wire active      = monitor & meas_en[c];
        wire sat         = (cnt_ff[c] == 8'hFF);
        wire stop        = (tach_rise[c] && edge_ff[c] == 2'h1) || sat;
        wire done        = (st_ff[c] == FANTM_CNT) && stop;
        wire [7:0] fin   = (cnt_tick && !sat && !tach_rise[c]) ?
                           cnt_ff[c] + 8'h01 : cnt_ff[c];
        assign fail_ev[c]  = done && (fin > lim_ff[c]);
        assign fault_ch[c] = (run_ff[c] == `FANTM_FAIL_RUN);
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                st_ff[c]   <= FANTM_IDLE;
                edge_ff[c] <= '0;
                cnt_ff[c]  <= '0;
                spd_ff[c]  <= '0;
                run_ff[c]  <= '0;
                spin_ff[c] <= '0;
            end
            else if (clk_en)
            begin
                if (spin_ff[c] != '0)
                    spin_ff[c] <= spin_ff[c] - 1'b1;
                if (fail_ev[c])
                    spin_ff[c] <= SPIN_W'(SPIN_CYC);
                unique case (st_ff[c])
                FANTM_IDLE:
                    if (active)
                    begin
                        st_ff[c]   <= FANTM_ARM;
                        edge_ff[c] <= '0;
                        cnt_ff[c]  <= '0;
                    end
                FANTM_ARM:
                    if (!active)
                        st_ff[c] <= FANTM_IDLE;
                    else if (tach_rise[c])
                    begin
                        edge_ff[c] <= edge_ff[c] + 2'h1;
                        if (edge_ff[c] == 2'h1)
                        begin
                            st_ff[c]   <= FANTM_CNT;
                            edge_ff[c] <= '0;
                        end
                    end
                FANTM_CNT:
                    if (!active)
                        st_ff[c] <= FANTM_IDLE;
                    else
                    begin
                        cnt_ff[c] <= fin;
                        if (tach_rise[c])
                            edge_ff[c] <= edge_ff[c] + 2'h1;
                        if (done)
                        begin
                            spd_ff[c] <= fin;
                            st_ff[c]  <= FANTM_DONE;
                            if (fail_ev[c])
                                run_ff[c] <= fault_ch[c] ? run_ff[c] :
                                             run_ff[c] + 3'h1;
                            else
                                run_ff[c] <= '0;
                        end
                    end
                FANTM_DONE:
                begin
                    // rearm at once so readings keep flowing
                    st_ff[c]   <= active ? FANTM_ARM : FANTM_IDLE;
                    edge_ff[c] <= '0;
                    cnt_ff[c]  <= '0;
                end
            endcase
                if (active && pwm_rise)
                begin
                    st_ff[c]   <= FANTM_ARM;
                    edge_ff[c] <= '0;
                    cnt_ff[c]  <= '0;
                end
            end
        end
    end

    // register file
    wire [7:0] stat_set = {5'h0, fail_ev[1], fail_ev[0], 1'b0};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg1_ff    <= `FANTM_RST_CFG1;
            cfg2_ff    <= `FANTM_RST_CFG2;
            char_ff[0] <= `FANTM_RST_CHAR;
            char_ff[1] <= `FANTM_RST_CHAR;
            lim_ff[0]  <= `FANTM_RST_LIM;
            lim_ff[1]  <= `FANTM_RST_LIM;
            spdset_ff  <= `FANTM_RST_SPDSET;
            filt_ff    <= `FANTM_RST_FILT;
            ltmr_ff    <= `FANTM_RST_LTMR;
            r1tmr_ff   <= `FANTM_RST_RTMR;
            r2tmr_ff   <= `FANTM_RST_RTMR;
            duty_ff    <= `FANTM_RST_DUTY;
            beh_ff     <= `FANTM_RST_BEH;
            stat1_ff   <= '0;
            int_ff     <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_go && addr_ok)
            begin
                unique case (idx)
                `FANTM_IDX_CFG1:   cfg1_ff    <= req.pwdata;
                `FANTM_IDX_CFG2:   cfg2_ff    <= req.pwdata;
                `FANTM_IDX_CHAR1:  char_ff[0] <= req.pwdata;
                `FANTM_IDX_CHAR2:  char_ff[1] <= req.pwdata;
                `FANTM_IDX_LIM1:   lim_ff[0]  <= req.pwdata;
                `FANTM_IDX_LIM2:   lim_ff[1]  <= req.pwdata;
                `FANTM_IDX_SPDSET: spdset_ff  <= req.pwdata;
                `FANTM_IDX_FILT:   filt_ff    <= req.pwdata;
                `FANTM_IDX_LTMR:   ltmr_ff    <= req.pwdata;
                `FANTM_IDX_R1TMR:  r1tmr_ff   <= req.pwdata;
                `FANTM_IDX_R2TMR:  r2tmr_ff   <= req.pwdata;
                `FANTM_IDX_DUTY:   duty_ff    <= req.pwdata;
                `FANTM_IDX_BEHREV: beh_ff     <= {req.pwdata[7], 7'h0};
                default:           ;
                endcase
            end
            // new failure wins over read-to-clear
            stat1_ff <= (stat_rd ? 8'h00 : stat1_ff) | stat_set;
            int_ff   <= (stat_rd ? 1'b0 : int_ff) | (|fail_ev);
        end
    end

    // read mux
    logic [7:0] rd_val;
    logic       rd_hit;
    always_comb
    begin
        rd_hit = 1'b1;
        unique case (idx)
        `FANTM_IDX_CFG1:   rd_val = cfg1_ff;
        `FANTM_IDX_CFG2:   rd_val = cfg2_ff;
        `FANTM_IDX_STAT1:  rd_val = stat1_ff;
        `FANTM_IDX_STAT2:  rd_val = 8'h00;
        `FANTM_IDX_SPD1:   rd_val = spd_ff[0];
        `FANTM_IDX_SPD2:   rd_val = spd_ff[1];
        `FANTM_IDX_LIM1:   rd_val = lim_ff[0];
        `FANTM_IDX_LIM2:   rd_val = lim_ff[1];
        `FANTM_IDX_CHAR1:  rd_val = char_ff[0];
        `FANTM_IDX_CHAR2:  rd_val = char_ff[1];
        `FANTM_IDX_SPDSET: rd_val = spdset_ff;
        `FANTM_IDX_FILT:   rd_val = filt_ff;
        `FANTM_IDX_LTMR:   rd_val = ltmr_ff;
        `FANTM_IDX_R1TMR:  rd_val = r1tmr_ff;
        `FANTM_IDX_R2TMR:  rd_val = r2tmr_ff;
        `FANTM_IDX_DUTY:   rd_val = duty_ff;
        `FANTM_IDX_DEVID:  rd_val = PART_ID;
        `FANTM_IDX_MAKID:  rd_val = MAKER_ID;
        `FANTM_IDX_BEHREV: rd_val = {beh_ff[7], 3'h0, REVISION};
        default:
        begin
            rd_val = 8'h00;
            rd_hit = 1'b0;
        end
        endcase
    end
    wire rd_ok = rd_hit & addr_ok;

    // one wait state: answer at second access edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end
        else if (clk_en)
        begin
            pready_ff  <= bus_go;
            pslverr_ff <= bus_go & ~(rd_ok | (req.pwrite & addr_ok));
            prdata_ff  <= rd_go ? {24'h0, rd_ok ? rd_val : 8'h00} : '0;
        end
    end

    // drive and fault pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwm_d_ff <= 1'b0;
            drive_ff <= '0;
            fault_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            pwm_d_ff <= pwm_raw;
            for (int c = 0; c < 2; c++)
                // spin-up overrides duty; invert bit set makes full duty read high, clear makes it low
                drive_ff[c] <= ((spin_ff[c] != '0) | pwm_raw)
                               ^ ~cfg1_ff[`FANTM_BIT_INV];
            fault_ff <= cfg1_ff[`FANTM_BIT_FFEN] & (|fault_ch);
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign int_o          = int_ff;
    assign fan_drive_out  = drive_ff;
    assign fan_fault_o    = 1'b0;
    assign fan_fault_oe_n = ~fault_ff;

    a_ready_once: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("pready held two cycles");
    a_int_clear_rd: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && stat_rd && !(|fail_ev)) |=> !int_o)
        else $error("interrupt not cleared by status read");
    a_fail_sets_int: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && |fail_ev) |=> int_o && (stat1_ff[2:1] != 2'h0))
        else $error("failure did not raise interrupt");
    a_fault_needs_five: assert property (@(posedge pclk)
        disable iff (!presetn)
        $fell(fan_fault_oe_n) |->
        ($past(run_ff[0]) == 3'h5 || $past(run_ff[1]) == 3'h5))
        else $error("fault pin without five failures");
    a_fault_gated: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !cfg1_ff[4]) |=> fan_fault_oe_n)
        else $error("fault driven while disabled");
    a_cnt_saturate: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && cnt_ff[0] == 8'hFF && st_ff[0] == FANTM_CNT)
        |=> cnt_ff[0] == 8'hFF)
        else $error("counter wrapped");
    a_limit_equal: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && fail_ev[0]) |=> spd_ff[0] > $past(lim_ff[0]))
        else $error("failure at reading equal to limit");
    a_spin_load: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && fail_ev[1]) |=> spin_ff[1] != '0)
        else $error("no spin-up after failure");
    a_idle_off: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !monitor && st_ff[0] == FANTM_CNT) |=>
        st_ff[0] == FANTM_IDLE)
        else $error("measurement ran while monitor off");
    c_fail: cover property (@(posedge pclk) fail_ev[0]);
    c_fault: cover property (@(posedge pclk) !fan_fault_oe_n);
    c_store: cover property (@(posedge pclk) st_ff[1] == FANTM_DONE);
endmodule

//--- tb/fantm_fan_model.sv
// behavioural cooling fan: free-running tach pulse train
module fantm_fan_model #(
    parameter int HALF_NS  = 22403,
    parameter int START_NS = 1000
)(
    // fan power
    input  wire logic run,
    // tach pin
    output logic      tach_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // stopped fan returns the pulled-up pin high, then no more edges
    initial
    begin
        tach_out = 1'b1;
        #(START_NS);
        forever
        begin
            #(HALF_NS);
            tach_out = run ? ~tach_out : 1'b1;
        end
    end
endmodule

//--- tb/test_fan_tach_measure_fault.sv
// self-checking bench for the fan tach measurement block
`include "fantm_cfg.svh"
`define FT_CHK(nm, got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("BAD %s exp %h got %h", nm, exp, got); \
        end \
    end
module test_fan_tach_measure_fault;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] PART  = 8'hC3; // arbitrary value
    localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
    localparam logic [3:0] REV   = 4'h3;
    typedef struct {
        string      nm;
        logic [7:0] exp;
        logic [7:0] msk;
        logic       err;
    } fantm_exp_s;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic [1:0]  tach, drive;
    logic        fault_o, fault_oe_n, int_o, ok, clk_en, fan_run;
    logic [7:0]  rd_last;
    logic [31:0] seed;
    int          errors, n_compared;
    fantm_exp_s  expq[$];
    fantm_exp_s  cur;
    logic [7:0]  rst_idx [16] = '{`FANTM_IDX_CFG1, `FANTM_IDX_CFG2,
        `FANTM_IDX_STAT1, `FANTM_IDX_STAT2, `FANTM_IDX_LIM1, `FANTM_IDX_LIM2,
        `FANTM_IDX_CHAR1, `FANTM_IDX_CHAR2, `FANTM_IDX_SPDSET,
        `FANTM_IDX_FILT, `FANTM_IDX_LTMR, `FANTM_IDX_R1TMR,
        `FANTM_IDX_R2TMR, `FANTM_IDX_DEVID, `FANTM_IDX_MAKID,
        `FANTM_IDX_BEHREV};
    logic [7:0]  rst_val [16] = '{8'h90, 8'h7F, 8'h00, 8'h00, 8'hFF, 8'hFF,
        8'h5D, 8'h5D, 8'h55, 8'h50, 8'h41, 8'h61, 8'h61, PART, MAKER,
        {4'h0, REV}};

    fantm_top #(
        .SPIN_CYC (200),
        .REF_DIV_CYC (500),
        .PART_ID  (PART),
        .MAKER_ID (MAKER),
        .REVISION (REV)
    ) u_dut (
        .pclk           (pclk),
        .presetn        (presetn),
        .clk_en         (clk_en),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .tach_sense_in  (tach),
        .fan_drive_out  (drive),
        .fan_fault_o    (fault_o),
        .fan_fault_oe_n (fault_oe_n),
        .int_o          (int_o)
    );
    // two fans, slow one on channel two, phases unrelated to pclk
    fantm_fan_model #(.HALF_NS(5003), .START_NS(777)) u_fan1 (
        .run      (fan_run),
        .tach_out (tach[0])
    );
    fantm_fan_model #(.HALF_NS(10007), .START_NS(3001)) u_fan2 (
        .run      (fan_run),
        .tach_out (tach[1])
    );

    always #4 pclk = ~pclk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one apb transfer; the monitor below judges the answer
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd, input string nm,
                       input logic [7:0] ex, input logic [7:0] mk,
                       input logic er);
        int k;
        expq.push_back('{nm, ex, mk, er});
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {22'h000000, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 50)
            `FT_CHK("pready", 1'b0, 1'b1)
        rd_last = prdata[7:0];
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        apb(1'b1, idx, v, "write", 8'h00, 8'h00, 1'b0);
    endtask

    task automatic rd(input logic [7:0] idx, input string nm,
                      input logic [7:0] ex, input logic [7:0] mk);
        apb(1'b0, idx, 8'h00, nm, ex, mk, 1'b0);
    endtask

    always @(posedge pclk)
    begin
        if (pready === 1'b1)
        begin
            if (expq.size() == 0)
                `FT_CHK("spare answer", 1'b1, 1'b0)
            else
            begin
                cur = expq.pop_front();
                `FT_CHK(cur.nm, prdata[7:0] & cur.msk, cur.exp & cur.msk)
                `FT_CHK(cur.nm, pslverr, cur.err)
            end
        end
    end

    // five failing measurements plus recovery take about 30k cycles
    initial
    begin
        repeat (90000) @(posedge pclk);
        errors++;
        $display("BAD watchdog exp done got hang");
        final_report();
    end

    initial
    begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = '0; pwdata = '0;
        clk_en = 1'b1; fan_run = 1'b1;
        errors = 0; n_compared = 0; seed = 32'h00002DD1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 16; i++)
            rd(rst_idx[i], "reset value", rst_val[i],
               (i == 15) ? 8'h8F : 8'hFF);
        `FT_CHK("fault idle", fault_oe_n, 1'b1)
        `FT_CHK("int idle", int_o, 1'b0)
        apb(1'b0, 8'h04, 8'h00, "unmapped", 8'h00, 8'hFF, 1'b1);
        wr(`FANTM_IDX_DEVID, 8'h00);
        rd(`FANTM_IDX_DEVID, "part id", PART, 8'hFF);
        seed = xs();
        wr(`FANTM_IDX_FILT, seed[7:0]);
        rd(`FANTM_IDX_FILT, "filter rw", seed[7:0], 8'hFF);
        $display("test registers done");
        // limit 0: any count of one or more fails
        wr(`FANTM_IDX_LIM1, 8'h00);
        wr(`FANTM_IDX_CHAR1, 8'h1D);
        wr(`FANTM_IDX_CFG1, 8'h99);
        for (int i = 0; i < 5; i++)
        begin
            for (int k = 0; k < 60000 && int_o !== 1'b1; k++)
                @(posedge pclk);
            @(posedge pclk);
            `FT_CHK("int raised", int_o, 1'b1)
            `FT_CHK("fault early", fault_oe_n, (i == 4) ? 1'b0 : 1'b1)
            ok = 1'b1;
            repeat (150)
            begin
                @(posedge pclk);
                ok &= (drive[0] === (i != 1));
            end
            `FT_CHK("spin drive", ok, 1'b1)
            rd(`FANTM_IDX_STAT1, "status", 8'h02, 8'h02);
            repeat (2) @(posedge pclk);
            `FT_CHK("int cleared", int_o, 1'b0)
            if (i == 0)
            begin
                rd(`FANTM_IDX_SPD1, "speed one", 8'h00, 8'h00);
                `FT_CHK("count one", rd_last inside {[4:6]}, 1'b1)
                wr(`FANTM_IDX_CFG1, 8'h91);
            end
            if (i == 1)
                wr(`FANTM_IDX_CFG1, 8'h99);
        end
        `FT_CHK("fault pin", {fault_oe_n, fault_o}, 2'b00)
        $display("test failures done");
        wr(`FANTM_IDX_LIM1, 8'hFF);
        for (int k = 0; k < 60000 && fault_oe_n !== 1'b1; k++)
            @(posedge pclk);
        `FT_CHK("fault released", fault_oe_n, 1'b1)
        rd(`FANTM_IDX_SPD2, "speed two", 8'h00, 8'h00);
        `FT_CHK("count two", rd_last inside {[4:6]}, 1'b1)
        $display("test recovery done");
        final_report();
    end
endmodule
